// File: bli_port.sv
// Bit-level two-wire serial port with Avalon-MM register slave.
// Assumes open-drain pads outside and one 250 MHz clock with synchronous reset.
//
// Summary of operation
// R1: A detected start sets the start event flag at the next filtered clock fall.
// R2: Writing zero to the start event bit clears it; one leaves it.
// R3: Interrupt request is start event gated by global and two-wire enables.
// R4: After a start the bus clock is held low until data register access.
// R5: Low seven event register bits read undefined; writes to them ignored.
// R6: Data register reads filtered data in bit 7, zeros below; write loads data out.
// R7: Filtered data input is latched at each rising filtered clock edge.
// R8: Data register bit 7 and control bit 7 share storage; no bit addressing.
// R9: Data register access clears start, rise, read-done, write-done flags and stretch.
// R10: Data register access starts automatic clock only when clock out bit is zero.
// R11: Automatic clock pulse starts 28 crystal periods after access, lasts 100.
// R12: If clock held low elsewhere, pulse counter pauses at 20 crystal periods.
// R13: Software tests read-done after reads and write-done after writes.
// R14: Software classifies failed reads by rise flag, clock input, bus-active.
// R15: Failed write without read causes means lost arbitration.
// R16: Control register read and write bit layouts as given.
// R17: Read-modify-write on top control bits uses data out and clock out bits.
// R18: Writing zero to rise flag clears it with read-done, write-done; one ignored.
// R19: Every rising filtered clock edge sets the rise flag.
// R20: Bus-active is set by start and cleared by stop.
// R21: With stretch enable set, every clock low period is stretched until access.
// R22: Start detection and stretching work only while interface enable is one.
// R23: Start is data falling with clock high; stop is data rising with clock high.
`timescale 1ns/10ps
`include "bli_cfg.svh"

module bli_port #(
  parameter int XTAL_DIV = `BLI_CLK_KHZ / `BLI_XTAL_KHZ,
  parameter int FILT_LEN = `BLI_FILT_CLKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM register slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire bli_pkg::bli_word_t avs_writedata_i,
  output bli_pkg::bli_word_t avs_readdata_o,
  output logic avs_waitrequest_o,
  // Two-wire bus pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Interrupt gating and request
  input wire logic global_irq_enable_i,
  input wire logic twowire_irq_enable_i,
  output logic irq_o
);
  import bli_pkg::*;

  // ----------------------------------------
  // Crystal-rate enable
  // ----------------------------------------
  logic [7:0] xdiv;
  wire xtal_tick = (xdiv == 8'(XTAL_DIV - 1));

  // One pulse per crystal period drives the automatic clock timing
  always_ff @(posedge clk_i) begin
    if (rst_i || xtal_tick) begin
      xdiv <= 8'h00;
    end else begin
      xdiv <= xdiv + 8'h01;
    end
  end

  // ----------------------------------------
  // Pin synchronisers and glitch filters
  // ----------------------------------------
  wire [1:0] pin_raw = {sda_i, scl_i};
  logic sync1 [2];
  logic sync2 [2];
  logic filt [2];
  logic [3:0] fcnt [2];

  // Input stage: two flops, then a level must hold FILT_LEN clocks to pass
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1[g] <= `BLI_RST_LINE;
          sync2[g] <= `BLI_RST_LINE;
          filt[g] <= `BLI_RST_LINE;
          fcnt[g] <= 4'h0;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
          if (sync2[g] == filt[g]) begin
            fcnt[g] <= 4'h0;
          end else if (fcnt[g] == 4'(FILT_LEN - 1)) begin
            filt[g] <= sync2[g];
            fcnt[g] <= 4'h0;
          end else begin
            fcnt[g] <= fcnt[g] + 4'h1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Bus edge and condition detection
  // ----------------------------------------
  logic scl_q;
  logic sda_q;
  wire filtered_clock_in = filt[0];
  wire filtered_sda = filt[1];

  // Previous filtered levels for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= `BLI_RST_LINE;
      sda_q <= `BLI_RST_LINE;
    end else begin
      scl_q <= filtered_clock_in;
      sda_q <= filtered_sda;
    end
  end

  logic interface_enable;
  wire scl_rise = filtered_clock_in & ~scl_q;
  wire scl_fall = ~filtered_clock_in & scl_q;
  wire scl_high = filtered_clock_in & scl_q;
  // Conditions only count while the clock stays high on both samples
  wire start_det = interface_enable & scl_high & sda_q & ~filtered_sda; // R23 R22
  wire stop_det = interface_enable & scl_high & ~sda_q & filtered_sda; // R23

  // ----------------------------------------
  // Avalon-MM slave: one wait state per access
  // ----------------------------------------
  logic ack_q;
  wire bus_req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack_q;
  wire acc_rd = avs_read_i & ack_q;
  wire acc_wr = avs_write_i & ack_q;
  wire hit_ctrl = (avs_address_i == {`BLI_IDX_CTRL, 2'b00});
  wire hit_data = (avs_address_i == {`BLI_IDX_DATA, 2'b00});
  wire hit_evt = (avs_address_i == {`BLI_IDX_EVENT, 2'b00});
  wire hit_mirror = (avs_address_i == {`BLI_IDX_MIRROR, 2'b00});
  wire [7:0] wbyte = avs_writedata_i[7:0];
  wire wr_ctrl = acc_wr & hit_ctrl;
  wire wr_evt = acc_wr & hit_evt;
  wire wr_data = acc_wr & hit_data;
  // Whole-register access only: any read or write of the data word counts
  wire data_access = (acc_rd | acc_wr) & hit_data; // R8 R9

  // Acknowledge toggles so each request sees exactly one wait cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // ----------------------------------------
  // Control bits written by software
  // ----------------------------------------
  logic data_out_bit;
  logic clock_out_bit;
  logic stretch_all_enable;

  // Data out is one storage bit for both the data and control words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_out_bit <= `BLI_RST_DOUT;
      clock_out_bit <= `BLI_RST_COUT;
      stretch_all_enable <= `BLI_RST_STR;
      interface_enable <= `BLI_RST_ENS;
    end else begin
      if (wr_data || wr_ctrl || (acc_wr && hit_mirror)) begin
        data_out_bit <= wbyte[`BLI_B_DATA]; // R6 R8 R17
      end
      if (wr_ctrl || (acc_wr && hit_mirror)) begin
        clock_out_bit <= wbyte[`BLI_B_CLK]; // R16 R17
        stretch_all_enable <= wbyte[`BLI_B_STR]; // R16
        interface_enable <= wbyte[`BLI_B_ENS]; // R16
      end
    end
  end

  // ----------------------------------------
  // Status flags; a hardware set always beats a clear
  // ----------------------------------------
  logic filtered_data_in;
  logic clock_rise_flag;
  logic bus_active_flag;
  logic read_bit_done;
  logic write_bit_done;
  logic arb_lost;
  logic start_pend;
  logic start_event;
  logic stretch_q;

  wire wr_ctrl_any = wr_ctrl | (acc_wr & hit_mirror);
  wire clr_rise = data_access | (wr_ctrl_any & ~wbyte[`BLI_B_RISE]); // R9 R18
  wire clr_start = data_access | (wr_evt & ~wbyte[`BLI_B_START]); // R2 R9
  // Pulse finished cleanly: had a rise, no start seen, no stop seen
  wire rdone_set = scl_fall & clock_rise_flag & bus_active_flag
                   & ~start_event & ~start_pend;
  wire lose_now = scl_rise & data_out_bit & ~filtered_sda;
  wire wdone_set = rdone_set & ~arb_lost;

  // Data bit is sampled on the filtered rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filtered_data_in <= `BLI_RST_LINE;
    end else if (scl_rise) begin
      filtered_data_in <= filtered_sda; // R7
    end
  end

  // Rise flag with its dependent completion flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_rise_flag <= 1'b0;
      read_bit_done <= 1'b0;
      write_bit_done <= 1'b0;
      arb_lost <= 1'b0;
    end else begin
      clock_rise_flag <= scl_rise | (clock_rise_flag & ~clr_rise); // R19 R18
      read_bit_done <= rdone_set | (read_bit_done & ~clr_rise); // R18
      write_bit_done <= wdone_set | (write_bit_done & ~clr_rise); // R18
      arb_lost <= lose_now | (arb_lost & ~clr_rise);
    end
  end

  // Bus activity tracking; disabling the port forgets the bus state
  always_ff @(posedge clk_i) begin
    if (rst_i || !interface_enable) begin
      bus_active_flag <= 1'b0;
      start_pend <= 1'b0;
    end else begin
      if (start_det) begin
        bus_active_flag <= 1'b1; // R20
      end else if (stop_det) begin
        bus_active_flag <= 1'b0; // R20
      end
      start_pend <= start_det | (start_pend & ~scl_fall & ~stop_det);
    end
  end

  // Start event flag raised at the first clock fall after a start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_event <= 1'b0;
    end else begin
      start_event <= (scl_fall & start_pend) | (start_event & ~clr_start); // R1 R2
    end
  end

  // Stretch latch pulls the clock low until software touches the data word
  always_ff @(posedge clk_i) begin
    if (rst_i || !interface_enable) begin
      stretch_q <= 1'b0; // R22
    end else begin
      stretch_q <= (scl_fall & (stretch_all_enable | start_pend)) // R4 R21
                   | (stretch_q & ~data_access); // R9
    end
  end

  // ----------------------------------------
  // Automatic clock sequencer
  // ----------------------------------------
  bli_ac_t ac_state;
  bli_ac_t next_ac_state;
  logic [6:0] ac_cnt;
  logic [6:0] next_ac_cnt;
  // Pulse only when the software clock bit is low; it is ORed onto the line
  wire ac_start = data_access & ~clock_out_bit; // R10
  wire ac_high = (ac_state == BLI_AC_HIGH);
  // Another device holding the line low freezes the count mid-pulse
  wire ac_hold = (ac_cnt == 7'(`BLI_AC_PAUSE_XTAL)) & ~filtered_clock_in; // R12

  // Next state: delay, then high pulse, counted in crystal periods
  always_comb begin
    next_ac_state = ac_state;
    next_ac_cnt = ac_cnt;
    if (ac_start) begin
      next_ac_state = BLI_AC_WAIT;
      next_ac_cnt = 7'h00;
    end else if (xtal_tick) begin
      unique case (ac_state)
        BLI_AC_IDLE: begin
          next_ac_cnt = 7'h00;
        end
        BLI_AC_WAIT: begin
          if (ac_cnt == 7'(`BLI_AC_DELAY_XTAL - 1)) begin
            next_ac_state = BLI_AC_HIGH; // R11
            next_ac_cnt = 7'h00;
          end else begin
            next_ac_cnt = ac_cnt + 7'h01;
          end
        end
        BLI_AC_HIGH: begin
          if (ac_hold) begin
            next_ac_cnt = ac_cnt; // R12
          end else if (ac_cnt == 7'(`BLI_AC_HIGH_XTAL - 1)) begin
            next_ac_state = BLI_AC_IDLE; // R11
            next_ac_cnt = 7'h00;
          end else begin
            next_ac_cnt = ac_cnt + 7'h01;
          end
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ac_state <= BLI_AC_IDLE;
      ac_cnt <= 7'h00;
    end else begin
      ac_state <= next_ac_state;
      ac_cnt <= next_ac_cnt;
    end
  end

  // ----------------------------------------
  // Pin drivers: open drain, enable low pulls the line low
  // ----------------------------------------
  wire scl_pull = ~(clock_out_bit | ac_high) | stretch_q; // R10 R4 R21
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // Registered enables keep glitches off the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_oe_n_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
      irq_o <= 1'b0;
    end else begin
      scl_oe_n_o <= ~scl_pull;
      sda_oe_n_o <= data_out_bit;
      irq_o <= start_event & global_irq_enable_i & twowire_irq_enable_i; // R3
    end
  end

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  wire [5:0] status_low = {clock_rise_flag, bus_active_flag, read_bit_done,
                           write_bit_done, stretch_all_enable, interface_enable};
  wire [7:0] ctrl_rd = {filtered_data_in, filtered_clock_in, status_low}; // R16
  // Output-latch view for read-modify-write of the top two bits
  wire [7:0] mirror_rd = {data_out_bit, clock_out_bit, status_low}; // R17
  wire [7:0] data_rd = {filtered_data_in, 7'h00}; // R6
  // Undefined low bits read as zero
  wire [7:0] evt_rd = {start_event, 7'h00}; // R5
  wire [7:0] rd_byte = hit_ctrl ? ctrl_rd :
                       hit_data ? data_rd :
                       hit_evt ? evt_rd :
                       hit_mirror ? mirror_rd : 8'h00;

  // Read word captured in the wait cycle, stands at the accepting edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      avs_readdata_o <= {24'h00_0000, rd_byte};
    end
  end

endmodule // bli_port

// File: bli_cfg.svh
// Constants of the bit-level two-wire port: register indexes, field positions,
// reset values and timing figures. Included by the package and the port.
`ifndef BLI_CFG_SVH
`define BLI_CFG_SVH
// ----------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------
`define BLI_IDX_CTRL 8'hd8
`define BLI_IDX_DATA 8'hd9
`define BLI_IDX_EVENT 8'hda
`define BLI_IDX_MIRROR 8'hdb
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BLI_B_DATA 7
`define BLI_B_CLK 6
`define BLI_B_RISE 5
`define BLI_B_BUSY 4
`define BLI_B_RDONE 3
`define BLI_B_WDONE 2
`define BLI_B_STR 1
`define BLI_B_ENS 0
`define BLI_B_START 7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define BLI_RST_DOUT 1'b1
`define BLI_RST_COUT 1'b1
`define BLI_RST_STR 1'b0
`define BLI_RST_ENS 1'b0
`define BLI_RST_LINE 1'b1
// ----------------------------------------
// Timing
// ----------------------------------------
`define BLI_CLK_KHZ 250000
`define BLI_XTAL_KHZ 16000
`define BLI_AC_DELAY_XTAL 28
`define BLI_AC_HIGH_XTAL 100
`define BLI_AC_PAUSE_XTAL 20
`define BLI_FILT_CLKS 3
`endif

// File: bli_pkg.sv
// Types shared by the bit-level two-wire port.
// Assumes bli_cfg.svh is on the include path.
package bli_pkg;
  `include "bli_cfg.svh"
  // Bus word of the register slave
  typedef logic [31:0] bli_word_t;
  // Automatic clock sequencer states
  typedef enum logic [1:0] {
    BLI_AC_IDLE,
    BLI_AC_WAIT,
    BLI_AC_HIGH
  } bli_ac_t;
endpackage

// File: bli_port_chk.sv
// Checker of the bit-level two-wire port, watching the top module's ports only.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/10ps
module bli_port_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire bli_pkg::bli_word_t avs_writedata_i,
  input wire bli_pkg::bli_word_t avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Pins and interrupt
  input wire logic scl_o,
  input wire logic scl_oe_n_o,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic global_irq_enable_i,
  input wire logic twowire_irq_enable_i,
  input wire logic irq_o
);
  import bli_pkg::*;
  // ----------------------------------------
  // Decoded transfers
  // ----------------------------------------
  wire logic req = avs_read_i | avs_write_i;
  wire logic take = req & ~avs_waitrequest_o;
  wire logic take_rd = take & avs_read_i;
  wire logic take_wr = take & avs_write_i;
  wire logic at_ctl = avs_address_i == 10'h360;
  wire logic at_dat = avs_address_i == 10'h364;
  wire logic at_evt = avs_address_i == 10'h368;
  wire logic at_mir = avs_address_i == 10'h36c;
  // Reset masks everything, since flags and outputs restart from fixed values
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_IRQ_GATE: assert property (irq_o |->
    $past(global_irq_enable_i) && $past(twowire_irq_enable_i))
    else $error("interrupt raised while an enable was low");
  AST_WAIT_FIRST: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("request answered without its wait cycle");
  AST_ONE_WAIT: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");
  AST_RD_HIGH: assert property (take_rd |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_DATA_LOW: assert property (take_rd && at_dat |-> avs_readdata_o[6:0] == 7'h0)
    else $error("data register low bits not zero");
  AST_EVT_LOW: assert property (take_rd && at_evt |-> avs_readdata_o[6:0] == 7'h0)
    else $error("event register low bits not zero");
  AST_UNMAPPED: assert property (take_rd && !(at_ctl || at_dat || at_evt || at_mir)
    |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_ACCESS_CLR: assert property (take && at_dat |-> ##[1:2] !irq_o)
    else $error("data access left the start event");
  AST_EVT_CLR: assert property (take_wr && at_evt && !avs_writedata_i[7] |-> ##[1:2] !irq_o)
    else $error("zero write left the start event");
  AST_SDO_PIN: assert property (take_wr && (at_dat || at_ctl || at_mir)
    |-> ##2 sda_oe_n_o == $past(avs_writedata_i[7], 2))
    else $error("data pin does not follow written bit");
  AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  // Main scenarios reached
  COV_IRQ: cover property ($rose(irq_o));
  COV_DATA_RD: cover property (take_rd && at_dat);
  COV_RELEASE: cover property ($rose(scl_oe_n_o));
endmodule // bli_port_chk

bind bli_port bli_port_chk chk (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .scl_o(scl_o),
  .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .global_irq_enable_i(global_irq_enable_i), .twowire_irq_enable_i(twowire_irq_enable_i),
  .irq_o(irq_o));

// File: bli_peer.sv
// Behavioural peer on the two-wire bus: another master or slave.
// Assumes pull-ups on both lines; a pull output of one drives its line low.
`timescale 1ns/10ps
module bli_peer (
  // Clock line level on the bus
  input wire logic scl_i,
  // Pull-down controls
  output logic scl_pull_o,
  output logic sda_pull_o
);
  // Half of the 64 ns link period; the clock stands still between frames
  localparam int HALF = 32;
  // Set when the clock stayed low past the peer's patience
  logic stalled = 1'b0;
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  // Start: data falls while the clock is high, then the clock falls
  task automatic start_cond();
    sda_pull_o = 1'b1;
    #HALF scl_pull_o = 1'b1;
    #HALF;
  endtask
  // One bit, waiting out stretching by the port for a bounded time
  task automatic send_bit(input logic b);
    int n;
    sda_pull_o = ~b;
    #HALF scl_pull_o = 1'b0;
    n = 0;
    while (!scl_i && n < 100) begin
      #4 n++;
    end
    if (n >= 100) begin
      stalled = 1'b1;
    end
    #HALF scl_pull_o = 1'b1;
    #HALF;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop_cond();
    sda_pull_o = 1'b1;
    #HALF scl_pull_o = 1'b0;
    #HALF sda_pull_o = 1'b0;
    #HALF;
  endtask
  // Hold the clock low, as a slow device would
  task automatic hold(input logic v);
    scl_pull_o = v;
  endtask
endmodule // bli_peer

// File: tb_bit_level_i2c_port.sv
// Self-checking bench of the bit-level two-wire port with a bus peer.
// Assumes the port, its checker and the peer model are compiled first.
`timescale 1ns/10ps
module tb_bit_level_i2c_port;
  import bli_pkg::*;
  // ----------------------------------------
  // Wiring and stimulus
  // ----------------------------------------
  localparam logic [9:0] A_CTL = 10'h360;
  localparam logic [9:0] A_DAT = 10'h364;
  localparam logic [9:0] A_EVT = 10'h368;
  localparam logic [9:0] A_MIR = 10'h36c;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] adr = 10'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  bli_word_t wdat = 32'h0;
  bli_word_t rdat;
  logic wreq, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, irq_o, p_scl, p_sda;
  logic gie = 1'b0;
  logic tie = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  // Wired-AND of both parties; pull-ups win when nobody pulls
  wire logic scl_w = (scl_oe_n_o ? 1'b1 : scl_o) & ~p_scl;
  wire logic sda_w = (sda_oe_n_o ? 1'b1 : sda_o) & ~p_sda;
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // Short crystal divider keeps the automatic clock runs brief
  bli_port #(.XTAL_DIV(2)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .global_irq_enable_i(gie), .twowire_irq_enable_i(tie), .irq_o(irq_o));
  bli_peer peer (.scl_i(scl_w), .scl_pull_o(p_scl), .sda_pull_o(p_sda));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Request held until waitrequest is sampled low at a rising edge; read data taken there
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    @(posedge clk_i);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++;
      summarize();
    end
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr8(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer(1'b0, a, 8'h0, q);
    check({24'h0, q}, {24'h0, exp});
  endtask
  // Cycles until the clock pin enable reaches v, bounded
  task automatic wait_oe(input logic v, output int n);
    n = 0;
    while (scl_oe_n_o !== v && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 1000) begin
      fail_count++;
      summarize();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk(A_MIR, 8'hc0);
    rd_chk(A_EVT, 8'h00);
    wr8(10'h3fc, 8'hff);
    rd_chk(10'h3fc, 8'h00);
    rd_chk(A_MIR, 8'hc0);
    $display("test reset done");
  endtask
  // Start while switched off is not seen
  task automatic t_off();
    peer.start_cond();
    rd_chk(A_EVT, 8'h00);
    rd_chk(A_MIR, 8'hc0);
    peer.stop_cond();
    wr8(A_CTL, 8'hc1);
    $display("test disabled done");
  endtask
  task automatic t_start();
    int n;
    @(posedge clk_i);
    gie <= 1'b1;
    tie <= 1'b1;
    peer.start_cond();
    wait_oe(1'b0, n);
    check(irq_o, 1'b1);
    rd_chk(A_EVT, 8'h80);
    wr8(A_EVT, 8'hff);
    rd_chk(A_EVT, 8'h80);
    @(posedge clk_i);
    tie <= 1'b0;
    repeat (2) @(negedge clk_i);
    check(irq_o, 1'b0);
    // Request raised again so the clearing write is seen on the interrupt too
    @(posedge clk_i);
    tie <= 1'b1;
    wr8(A_EVT, 8'h00);
    rd_chk(A_EVT, 8'h00);
    check(irq_o, 1'b0);
    check(scl_oe_n_o, 1'b0);
    wr8(A_DAT, 8'h80);
    wait_oe(1'b1, n);
    check({31'h0, n < 20}, 32'h1);
    $display("test start done");
  endtask
  // Peer drives 0 over our 1: reads as done, write lost to arbitration
  task automatic t_bit();
    peer.send_bit(1'b0);
    rd_chk(A_CTL, 8'h39);
    rd_chk(A_MIR, 8'hf9);
    wr8(A_CTL, 8'he1);
    rd_chk(A_CTL, 8'h39);
    wr8(A_CTL, 8'hc1);
    rd_chk(A_CTL, 8'h11);
    rd_chk(A_DAT, 8'h00);
    $display("test bit done");
  endtask
  task automatic t_stretch();
    int n;
    wr8(A_CTL, 8'hc3);
    peer.send_bit(1'b1);
    check(scl_oe_n_o, 1'b0);
    rd_chk(A_CTL, 8'hbf);
    rd_chk(A_DAT, 8'h80);
    wait_oe(1'b1, n);
    check({31'h0, n < 20}, 32'h1);
    wr8(A_CTL, 8'hc1);
    peer.stop_cond();
    rd_chk(A_CTL, 8'h61);
    $display("test stretch done");
  endtask
  // Data bit storage is shared; clock out at one inhibits the automatic clock
  task automatic t_shared();
    wr8(A_CTL, 8'hc0);
    wr8(A_DAT, 8'h00);
    rd_chk(A_MIR, 8'h40);
    check(sda_oe_n_o, 1'b0);
    wr8(A_DAT, 8'h80);
    wr8(A_MIR, 8'h81);
    rd_chk(A_MIR, 8'h81);
    // The pulled clock line needs the synchroniser and filter before it reads low
    repeat (8) @(posedge clk_i);
    rd_chk(A_CTL, 8'h01);
    $display("test shared done");
  endtask
  task automatic t_auto();
    int n;
    wr8(A_DAT, 8'h80);
    wait_oe(1'b1, n);
    check({31'h0, n >= 55 && n <= 60}, 32'h1);
    wait_oe(1'b0, n);
    check({31'h0, n >= 198 && n <= 202}, 32'h1);
    $display("test autoclock done");
  endtask
  // Peer holds the clock low across the pulse start
  task automatic t_pause();
    int n;
    peer.hold(1'b1);
    wr8(A_DAT, 8'h80);
    wait_oe(1'b1, n);
    repeat (60) @(negedge clk_i);
    peer.hold(1'b0);
    wait_oe(1'b0, n);
    check({31'h0, n >= 160 && n <= 175}, 32'h1);
    wr8(A_MIR, 8'hc1);
    $display("test pause done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_off();
    t_start();
    t_bit();
    t_stretch();
    t_shared();
    t_auto();
    t_pause();
    check(peer.stalled, 1'b0);
    summarize();
  end
endmodule // tb_bit_level_i2c_port
